// File: twm_ctrl.sv
// two-wire master transmitter with software completion handshake, apb slave
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps
// Summary of operation
// - one byte per operation, flag marks completion
// - irq only with enable bit and global enable
// - status holds event code while flag set
// - writing one to flag bit clears it
// - no new operation while flag set
// - clearing flag starts the selected operation
// - after start set flag, post start code
// - after address set flag, code shows ack
// - after data byte set flag, code shows ack
// - stop completes without flag or status
// - scl held low while flag set
// - operation follows bits of the clearing write
// - code appears cycle after flag, else no-info
// - start code is 08
// - address ack 18, data ack 28
// - data write with flag low: discard, collision
module twm_ctrl (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // processor interrupt
  input  wire logic        gie_in,
  output logic             irq_req,
  // bus pins, enables active low
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n
);
  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
    reg_hit = (a == off);
  endfunction : reg_hit

  function automatic logic scl_low(input twm_pkg::twm_state_t s);
    scl_low = (s == twm_pkg::S_HOLD) || (s == twm_pkg::S_RS1) || (s == twm_pkg::S_STA2) ||
              (s == twm_pkg::S_BLO) || (s == twm_pkg::S_ALO) || (s == twm_pkg::S_SP1);
  endfunction : scl_low

  function automatic logic sda_low(input twm_pkg::twm_state_t s, input logic b);
    sda_low = (s == twm_pkg::S_STA1) || (s == twm_pkg::S_STA2) || (s == twm_pkg::S_SP1) ||
              (s == twm_pkg::S_SP2) || (((s == twm_pkg::S_BLO) || (s == twm_pkg::S_BHI)) && !b);
  endfunction : sda_low

  // pin synchronisers and half-period timer
  logic [1:0]  pins_s;
  logic        scl_s;
  logic        sda_s;
  logic        tick;
  logic        tick_run;
  logic [14:0] half_lim;

  // software-visible state
  logic        flag_r, flag_nxt;
  logic        acken_r, acken_nxt;
  logic        sta_r, sta_nxt;
  logic        sto_r, sto_nxt;
  logic        wcol_r, wcol_nxt;
  logic        en_r, en_nxt;
  logic        ie_r, ie_nxt;
  logic [7:0]  rate_r, rate_nxt;
  logic [1:0]  ps_r, ps_nxt;
  logic [7:0]  shift_r, shift_nxt;
  logic [7:0]  code_r, code_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic        scl_oen_r, scl_oen_nxt;
  logic        sda_oen_r, sda_oen_nxt;

  // engine state
  twm_pkg::twm_state_t st_r, st_nxt;
  logic [2:0]  bit_r, bit_nxt;
  logic        owned_r, owned_nxt;
  logic        addr_r, addr_nxt;
  logic        rs_r, rs_nxt;
  logic [7:0]  evt_r, evt_nxt;
  logic        set_evt;
  logic        sto_clr;

  logic mapped, wr_en, wr_ctrl, wr_stat, wr_data, wr_rate, launch, rest;

  twm_sync #(.W(2)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .raw_i   ({scl_i, sda_i}),
    .level_o (pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  assign half_lim = twm_pkg::HALF_BASE + ({7'h00, rate_r} << {ps_r, 1'b0});
  assign rest     = (st_r == twm_pkg::S_IDLE) || (st_r == twm_pkg::S_HOLD);
  // released scl waits for the line to rise, so slaves may stretch
  assign tick_run = en_r && !rest && (!scl_oen_r || scl_s);

  twm_tick u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (tick_run),
    .limit   (half_lim),
    .tick    (tick)
  );

  // apb decode, zero wait states
  assign mapped  = reg_hit(paddr, twm_pkg::CTRL_OFF) || reg_hit(paddr, twm_pkg::STAT_OFF) ||
                   reg_hit(paddr, twm_pkg::DATA_OFF) || reg_hit(paddr, twm_pkg::RATE_OFF);
  assign pready  = psel && penable;
  assign pslverr = pready && !mapped;
  assign wr_en   = pready && pwrite;
  assign wr_ctrl = wr_en && reg_hit(paddr, twm_pkg::CTRL_OFF);
  assign wr_stat = wr_en && reg_hit(paddr, twm_pkg::STAT_OFF);
  assign wr_data = wr_en && reg_hit(paddr, twm_pkg::DATA_OFF);
  assign wr_rate = wr_en && reg_hit(paddr, twm_pkg::RATE_OFF);
  // a flag-clearing write is the only trigger
  assign launch  = wr_ctrl && pwdata[twm_pkg::FLAG_B] && pwdata[twm_pkg::EN_B] && rest;

  // bus engine
  always_comb begin
    st_nxt    = st_r;
    bit_nxt   = bit_r;
    owned_nxt = owned_r;
    addr_nxt  = addr_r;
    rs_nxt    = rs_r;
    evt_nxt   = evt_r;
    set_evt   = 1'b0;
    sto_clr   = 1'b0;
    case (st_r)
      twm_pkg::S_IDLE, twm_pkg::S_HOLD: begin
        if (launch) begin
          if (pwdata[twm_pkg::STA_B] && !pwdata[twm_pkg::STO_B]) begin
            rs_nxt = owned_r;
            st_nxt = owned_r ? twm_pkg::S_RS1 : twm_pkg::S_STA1;
          end else if (pwdata[twm_pkg::STO_B]) begin
            st_nxt  = owned_r ? twm_pkg::S_SP1 : twm_pkg::S_IDLE;
            sto_clr = !owned_r;
          end else begin
            st_nxt  = twm_pkg::S_BLO;
            bit_nxt = twm_pkg::BIT_MSB;
          end
        end
      end
      twm_pkg::S_RS1: if (tick) st_nxt = twm_pkg::S_RS2;
      twm_pkg::S_RS2: if (tick) st_nxt = twm_pkg::S_STA1;
      twm_pkg::S_STA1: begin
        if (tick) begin
          st_nxt    = twm_pkg::S_STA2;
          owned_nxt = 1'b1;
        end
      end
      twm_pkg::S_STA2: begin
        if (tick) begin
          st_nxt   = twm_pkg::S_HOLD;
          set_evt  = 1'b1;
          evt_nxt  = rs_r ? twm_pkg::CODE_RSTART : twm_pkg::CODE_START;
          addr_nxt = 1'b1;
        end
      end
      twm_pkg::S_BLO: if (tick) st_nxt = twm_pkg::S_BHI;
      twm_pkg::S_BHI: begin
        if (tick) begin
          if (shift_r[bit_r] && !sda_s) begin
            st_nxt    = twm_pkg::S_IDLE;
            owned_nxt = 1'b0;
            set_evt   = 1'b1;
            evt_nxt   = twm_pkg::CODE_ARB_LOST;
          end else if (bit_r == 3'h0) begin
            st_nxt = twm_pkg::S_ALO;
          end else begin
            st_nxt  = twm_pkg::S_BLO;
            bit_nxt = bit_r - 3'h1;
          end
        end
      end
      twm_pkg::S_ALO: if (tick) st_nxt = twm_pkg::S_AHI;
      twm_pkg::S_AHI: begin
        if (tick) begin
          st_nxt   = twm_pkg::S_HOLD;
          set_evt  = 1'b1;
          addr_nxt = 1'b0;
          if (addr_r) begin
            evt_nxt = sda_s ? twm_pkg::CODE_ADDR_NAK : twm_pkg::CODE_ADDR_ACK;
          end else begin
            evt_nxt = sda_s ? twm_pkg::CODE_DATA_NAK : twm_pkg::CODE_DATA_ACK;
          end
        end
      end
      twm_pkg::S_SP1: if (tick) st_nxt = twm_pkg::S_SP2;
      twm_pkg::S_SP2: if (tick) st_nxt = twm_pkg::S_SP3;
      twm_pkg::S_SP3: begin
        if (tick) begin
          st_nxt    = twm_pkg::S_IDLE;
          owned_nxt = 1'b0;
          sto_clr   = 1'b1;
        end
      end
      default: st_nxt = twm_pkg::S_IDLE;
    endcase
    // enable may arrive in the same write that launches
    if (!en_r && !launch) begin
      st_nxt    = twm_pkg::S_IDLE;
      owned_nxt = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r    <= twm_pkg::S_IDLE;
      bit_r   <= twm_pkg::BIT_MSB;
      owned_r <= 1'b0;
      addr_r  <= 1'b0;
      rs_r    <= 1'b0;
      evt_r   <= twm_pkg::CODE_NO_INFO;
    end else begin
      st_r    <= st_nxt;
      bit_r   <= bit_nxt;
      owned_r <= owned_nxt;
      addr_r  <= addr_nxt;
      rs_r    <= rs_nxt;
      evt_r   <= evt_nxt;
    end
  end

  // registers, read data and pin drivers
  always_comb begin
    flag_nxt  = flag_r;
    acken_nxt = acken_r;
    sta_nxt   = sta_r;
    sto_nxt   = sto_r;
    wcol_nxt  = wcol_r;
    en_nxt    = en_r;
    ie_nxt    = ie_r;
    rate_nxt  = rate_r;
    ps_nxt    = ps_r;
    shift_nxt = shift_r;
    rd_nxt    = rd_r;
    if (wr_ctrl) begin
      acken_nxt = pwdata[twm_pkg::ACKEN_B];
      sta_nxt   = pwdata[twm_pkg::STA_B];
      sto_nxt   = pwdata[twm_pkg::STO_B];
      en_nxt    = pwdata[twm_pkg::EN_B];
      ie_nxt    = pwdata[twm_pkg::IE_B];
      if (pwdata[twm_pkg::FLAG_B]) begin
        flag_nxt = 1'b0;
      end
    end
    if (set_evt) begin
      flag_nxt = 1'b1;
    end
    if (sto_clr && (launch || !wr_ctrl)) begin
      sto_nxt = 1'b0;
    end
    if (wr_data) begin
      if (flag_r) begin
        shift_nxt = pwdata[7:0];
        wcol_nxt  = 1'b0;
      end else begin
        wcol_nxt = 1'b1;
      end
    end
    if (wr_stat) begin
      ps_nxt = pwdata[twm_pkg::PS_MSB:0];
    end
    if (wr_rate) begin
      rate_nxt = pwdata[7:0];
    end
    // code trails the flag by one cycle
    code_nxt = flag_r ? evt_r : twm_pkg::CODE_NO_INFO;
    if (psel && !penable && !pwrite) begin
      rd_nxt = 32'h0000_0000;
      if (reg_hit(paddr, twm_pkg::CTRL_OFF)) begin
        rd_nxt[7:0] = {flag_r, acken_r, sta_r, sto_r, wcol_r, en_r, 1'b0, ie_r};
      end else if (reg_hit(paddr, twm_pkg::STAT_OFF)) begin
        rd_nxt[7:0] = {code_r[7:twm_pkg::CODE_LSB], 1'b0, ps_r};
      end else if (reg_hit(paddr, twm_pkg::DATA_OFF)) begin
        rd_nxt[7:0] = shift_r;
      end else if (reg_hit(paddr, twm_pkg::RATE_OFF)) begin
        rd_nxt[7:0] = rate_r;
      end
    end
    scl_oen_nxt = !(scl_low(st_nxt) || flag_nxt);
    // sda moves a cycle after scl falls, keeps hold time
    sda_oen_nxt = !sda_low(st_r, shift_r[bit_r]);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r    <= 1'b0;
      acken_r   <= 1'b0;
      sta_r     <= 1'b0;
      sto_r     <= 1'b0;
      wcol_r    <= 1'b0;
      en_r      <= 1'b0;
      ie_r      <= 1'b0;
      rate_r    <= twm_pkg::RATE_RST;
      ps_r      <= twm_pkg::PS_RST;
      shift_r   <= twm_pkg::SHIFT_RST;
      code_r    <= twm_pkg::CODE_NO_INFO;
      rd_r      <= 32'h0000_0000;
      scl_oen_r <= 1'b1;
      sda_oen_r <= 1'b1;
    end else begin
      flag_r    <= flag_nxt;
      acken_r   <= acken_nxt;
      sta_r     <= sta_nxt;
      sto_r     <= sto_nxt;
      wcol_r    <= wcol_nxt;
      en_r      <= en_nxt;
      ie_r      <= ie_nxt;
      rate_r    <= rate_nxt;
      ps_r      <= ps_nxt;
      shift_r   <= shift_nxt;
      code_r    <= code_nxt;
      rd_r      <= rd_nxt;
      scl_oen_r <= scl_oen_nxt;
      sda_oen_r <= sda_oen_nxt;
    end
  end

  assign prdata   = rd_r;
  assign irq_req  = flag_r && ie_r && gie_in;
  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;
  assign scl_oe_n = scl_oen_r;
  assign sda_oe_n = sda_oen_r;

  a_code_after_flag: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(flag_r) |=> (code_r == evt_r) && flag_r) else $error("status code not loaded after flag");
  a_noinfo_clear: assert property (@(posedge pclk) disable iff (!presetn)
    !flag_r ##1 !flag_r |-> code_r == twm_pkg::CODE_NO_INFO) else $error("status not no-info while flag low");
  a_irq_gating: assert property (@(posedge pclk) disable iff (!presetn)
    irq_req |-> flag_r && ie_r && gie_in) else $error("interrupt without enables");
  a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctrl && pwdata[twm_pkg::FLAG_B] && !set_evt) |=> !flag_r) else $error("flag not cleared by write");
  a_zero_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctrl && !pwdata[twm_pkg::FLAG_B] && flag_r) |=> flag_r && $stable(st_r)) else $error("zero write acted");
  a_scl_stretch: assert property (@(posedge pclk) disable iff (!presetn)
    flag_r |-> !scl_oe_n) else $error("scl released while flag set");
  a_idle_while_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (flag_r && !(wr_ctrl && pwdata[twm_pkg::FLAG_B])) |=> $stable(st_r)) else $error("operation began under flag");
  a_start_code: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r == twm_pkg::S_STA2 && tick && !rs_r) |=> flag_r ##1 code_r == twm_pkg::CODE_START)
    else $error("start code wrong");
  a_stop_silent: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r == twm_pkg::S_SP3 && tick && !wr_ctrl) |=> !flag_r && st_r == twm_pkg::S_IDLE) else $error("stop raised flag");
  a_write_collide: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_data && !flag_r) |=> wcol_r && shift_r == $past(shift_r)) else $error("collision not handled");
  a_launch_moves: assert property (@(posedge pclk) disable iff (!presetn)
    (launch && !pwdata[twm_pkg::STO_B]) |=> st_r != twm_pkg::S_HOLD && !flag_r) else $error("launch did not start");
endmodule : twm_ctrl

// File: twm_pkg.sv
// shared constants and types of the two-wire master handshake block
package twm_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam logic [7:0] DATA_OFF = 8'h08;
  localparam logic [7:0] RATE_OFF = 8'h0c;
  // control_reg field positions
  localparam int FLAG_B  = 7;
  localparam int ACKEN_B = 6;
  localparam int STA_B   = 5;
  localparam int STO_B   = 4;
  localparam int WCOL_B  = 3;
  localparam int EN_B    = 2;
  localparam int IE_B    = 0;
  // status_reg field positions
  localparam int CODE_LSB = 3;
  localparam int PS_MSB   = 1;
  // status codes, prescale bits masked
  localparam logic [7:0] CODE_START    = 8'h08;
  localparam logic [7:0] CODE_RSTART   = 8'h10;
  localparam logic [7:0] CODE_ADDR_ACK = 8'h18;
  localparam logic [7:0] CODE_ADDR_NAK = 8'h20;
  localparam logic [7:0] CODE_DATA_ACK = 8'h28;
  localparam logic [7:0] CODE_DATA_NAK = 8'h30;
  localparam logic [7:0] CODE_ARB_LOST = 8'h38;
  localparam logic [7:0] CODE_NO_INFO  = 8'hf8;
  // reset values
  localparam logic [7:0] RATE_RST  = 8'h00;
  localparam logic [7:0] SHIFT_RST = 8'hff;
  localparam logic [1:0] PS_RST    = 2'h0;
  // half bus-clock period in cycles is HALF_BASE + 1 + rate * 4^prescale
  localparam logic [14:0] HALF_BASE = 15'h0007;
  localparam logic [2:0]  BIT_MSB   = 3'h7;

  typedef enum logic [3:0] {
    S_IDLE, S_HOLD, S_RS1, S_RS2, S_STA1, S_STA2,
    S_BLO, S_BHI, S_ALO, S_AHI, S_SP1, S_SP2, S_SP3
  } twm_state_t;
endpackage : twm_pkg

// File: twm_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module twm_sync #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // raw and filtered levels
  input  wire logic [W-1:0] raw_i,
  output logic      [W-1:0] level_o
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] lvl_r;
  logic [W-1:0] lvl_nxt;

  // change accepted once stages two and three agree
  always_comb begin
    lvl_nxt = lvl_r;
    for (int i = 0; i < W; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        lvl_nxt[i] = s3_r[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r  <= '1;
      s2_r  <= '1;
      s3_r  <= '1;
      lvl_r <= '1;
    end else begin
      s1_r  <= raw_i;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  assign level_o = lvl_r;
endmodule : twm_sync

// File: twm_tick.sv
// half-period enable pulse generator for the bus clock
`timescale 1ns/1ps
module twm_tick (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // control
  input  wire logic        run,
  input  wire logic [14:0] limit,
  // one-cycle enable
  output logic             tick
);
  logic [14:0] cnt_r;
  logic [14:0] cnt_nxt;
  logic        tick_r;
  logic        tick_nxt;

  always_comb begin
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (!run) begin
      cnt_nxt = 15'h0000;
    end else if (cnt_r >= limit) begin
      cnt_nxt  = 15'h0000;
      tick_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + 15'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r  <= 15'h0000;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;
endmodule : twm_tick

// File: twm_slave_model.sv
// behavioural two-wire slave receiver standing on the far side of the bus
`timescale 1ns/1ps
module twm_slave_model (
  // wire levels
  input  wire logic scl,
  input  wire logic sda,
  // behaviour control
  input  wire logic ack_en,
  input  wire logic slow,
  // open-drain pulls, high pulls the line low
  output logic      scl_low,
  output logic      sda_low
);
  logic [7:0] shift_r;
  logic [7:0] got_q[$];
  logic       active;
  int         nbits;

  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    active  = 1'b0;
    nbits   = 0;
  end
  // start and stop: sda moves while scl is high
  always @(negedge sda) if (scl === 1'b1) begin
    active = 1'b1;
    nbits  = 0;
  end
  always @(posedge sda) if (scl === 1'b1) active = 1'b0;
  always @(posedge scl) if (active && nbits < 8) begin
    shift_r = {shift_r[6:0], sda};
    nbits++;
    if (nbits == 8) got_q.push_back(shift_r);
  end
  always @(negedge scl) begin
    if (active && nbits == 8) begin
      sda_low = ack_en;
      nbits   = 9;
    end else if (nbits == 9) begin
      sda_low = 1'b0;
      nbits   = 0;
    end
    // a slow slave keeps the clock low a while
    if (slow) begin
      scl_low = 1'b1;
      #1000 scl_low = 1'b0;
    end
  end
endmodule : twm_slave_model

// File: twm_ctrl_test.sv
// self-checking bench for the two-wire master handshake controller
`timescale 1ns/1ps
module twm_ctrl_test;
  typedef struct packed {
    logic [7:0] cmd;
    logic       load;
    logic [7:0] data;
    logic       ack;
    logic       slow;
    logic [7:0] code;
  } twm_row_t;
  localparam logic [7:0] FLG = 8'h01 << twm_pkg::FLAG_B;
  localparam logic [7:0] GO  = FLG | (8'h01 << twm_pkg::EN_B);
  localparam logic [7:0] STA = 8'h01 << twm_pkg::STA_B;
  localparam logic [7:0] STO = 8'h01 << twm_pkg::STO_B;
  localparam logic [7:0] IE  = 8'h01 << twm_pkg::IE_B;
  logic        pclk, presetn, psel, penable, pwrite, gie_in, ack_en, slow, err;
  logic        pready, pslverr, irq_req, scl_o, scl_oe_n, sda_o, sda_oe_n, scl_low, sda_low;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  wire         scl_line, sda_line;
  int          err_total, samples_checked;
  twm_row_t    rows [6] = '{
    '{GO | STA,      1'b0, 8'h00, 1'b1, 1'b0, twm_pkg::CODE_START},
    '{GO | IE,       1'b1, 8'ha0, 1'b1, 1'b0, twm_pkg::CODE_ADDR_ACK},
    '{GO,            1'b1, 8'h5a, 1'b1, 1'b1, twm_pkg::CODE_DATA_ACK},
    '{GO | IE,       1'b1, 8'hc3, 1'b0, 1'b0, twm_pkg::CODE_DATA_NAK},
    '{GO | STA | IE, 1'b0, 8'h00, 1'b1, 1'b0, twm_pkg::CODE_RSTART},
    '{GO,            1'b1, 8'ha2, 1'b0, 1'b0, twm_pkg::CODE_ADDR_NAK}
  };

  // open-drain lines with pull-ups
  assign scl_line = scl_oe_n ? ~scl_low : scl_o;
  assign sda_line = sda_oe_n ? ~sda_low : sda_o;

  twm_ctrl dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gie_in(gie_in), .irq_req(irq_req), .scl_i(scl_line), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n(sda_oe_n)
  );
  twm_slave_model slave_u (
    .scl(scl_line), .sda(sda_line), .ack_en(ack_en), .slow(slow), .scl_low(scl_low), .sda_low(sda_low)
  );

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // one apb transfer, result left in rd and err
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk(32'h0, 32'h1, "apb answer timeout");
      end_sim();
    end
    @(posedge pclk);
  endtask : apb

  task automatic wait_flag();
    int n;
    n = 0;
    do begin
      apb(1'b0, twm_pkg::CTRL_OFF, 32'h0);
      n++;
    end while (rd[twm_pkg::FLAG_B] !== 1'b1 && n < 500);
    if (rd[twm_pkg::FLAG_B] !== 1'b1) begin
      chk(32'h0, 32'h1, "completion flag never set");
      end_sim();
    end
  endtask : wait_flag

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    gie_in = 1'b0;
    ack_en = 1'b1;
    slow = 1'b0;
    rd = 32'h0;
    err = 1'b0;
    err_total = 0;
    samples_checked = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, twm_pkg::CTRL_OFF, 32'h0);
    chk(rd, 32'h0, "ctrl reset");
    apb(1'b0, twm_pkg::STAT_OFF, 32'h0);
    chk(rd, {24'h0, twm_pkg::CODE_NO_INFO}, "stat reset");
    apb(1'b0, twm_pkg::RATE_OFF, 32'h0);
    chk(rd, {24'h0, twm_pkg::RATE_RST}, "rate reset");
    apb(1'b0, 8'h10, 32'h0);
    chk({rd[30:0], err}, 32'h1, "unmapped read");
    apb(1'b1, 8'h10, 32'hff);
    chk({31'h0, err}, 32'h1, "unmapped write");
    apb(1'b1, twm_pkg::DATA_OFF, 32'h77);
    apb(1'b0, twm_pkg::DATA_OFF, 32'h0);
    chk(rd, {24'h0, twm_pkg::SHIFT_RST}, "data write discarded");
    apb(1'b0, twm_pkg::CTRL_OFF, 32'h0);
    chk(rd, 32'h1 << twm_pkg::WCOL_B, "write collision");
    apb(1'b1, twm_pkg::RATE_OFF, 32'h1);
    apb(1'b1, twm_pkg::STAT_OFF, 32'h1);
    apb(1'b0, twm_pkg::STAT_OFF, 32'h0);
    chk(rd, {24'h0, twm_pkg::CODE_NO_INFO} | 32'h1, "prescale bits");
    $display("test reset done");
    foreach (rows[i]) begin
      ack_en <= rows[i].ack;
      slow   <= rows[i].slow;
      gie_in <= i[0];
      if (rows[i].load) apb(1'b1, twm_pkg::DATA_OFF, {24'h0, rows[i].data});
      apb(1'b1, twm_pkg::CTRL_OFF, {24'h0, rows[i].cmd});
      apb(1'b0, twm_pkg::STAT_OFF, 32'h0);
      chk(rd, {24'h0, twm_pkg::CODE_NO_INFO} | 32'h1, "status while busy");
      wait_flag();
      apb(1'b0, twm_pkg::STAT_OFF, 32'h0);
      chk(rd & 32'hf8, {24'h0, rows[i].code}, "status code");
      chk({31'h0, irq_req}, {31'h0, rows[i].cmd[twm_pkg::IE_B] & i[0]}, "irq");
      chk({31'h0, scl_line}, 32'h0, "scl held low");
      if (rows[i].load) chk({24'h0, slave_u.got_q[$]}, {24'h0, rows[i].data}, "byte on wire");
      $display("test row %0d done", i);
    end
    apb(1'b1, twm_pkg::CTRL_OFF, {24'h0, (GO & ~FLG) | STA});
    repeat (200) @(posedge pclk);
    apb(1'b0, twm_pkg::CTRL_OFF, 32'h0);
    chk({31'h0, rd[twm_pkg::FLAG_B]}, 32'h1, "flag kept");
    chk({31'h0, scl_line}, 32'h0, "scl stretched");
    apb(1'b0, twm_pkg::STAT_OFF, 32'h0);
    chk(rd & 32'hf8, {24'h0, twm_pkg::CODE_ADDR_NAK}, "no new operation");
    $display("test hold done");
    apb(1'b1, twm_pkg::CTRL_OFF, {24'h0, GO | STO});
    repeat (100) @(posedge pclk);
    apb(1'b0, twm_pkg::CTRL_OFF, 32'h0);
    chk(rd & {24'h0, FLG | STO}, 32'h0, "stop leaves flag clear");
    apb(1'b0, twm_pkg::STAT_OFF, 32'h0);
    chk(rd, {24'h0, twm_pkg::CODE_NO_INFO} | 32'h1, "no stop event");
    chk({30'h0, scl_line, sda_line}, 32'h3, "bus released");
    chk({31'h0, slave_u.active}, 32'h0, "stop seen by slave");
    apb(1'b1, twm_pkg::CTRL_OFF, {24'h0, GO | STO});
    apb(1'b0, twm_pkg::CTRL_OFF, 32'h0);
    chk(rd & {24'h0, FLG | STO}, 32'h0, "stop on free bus");
    $display("test stop done");
    end_sim();
  end
endmodule : twm_ctrl_test
